// *** asr_readout.sv ***
// Serial result readout and conversion timing of an 8-channel converter
`timescale 1ns/1ps
`default_nettype none
module asr_readout
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Serial pins from host
  input wire logic i_frame_sel_n,
  input wire logic i_sclk,
  input wire logic i_sdin,
  // Serial output pin, two signals: data and enable
  output logic o_sdout,
  output logic o_sdout_oe,
  // Converter core side
  input wire logic [asr_pkg::DATA_BITS-1:0] i_sample_mag,
  input wire logic i_sample_neg,
  input wire logic i_twos_comp,
  output logic o_track,
  output logic [asr_pkg::CHAN_BITS-1:0] o_channel_address,
  // Captured input word and result stream
  output logic [asr_pkg::FRAME_BITS-1:0] o_din_word,
  output logic o_result_valid,
  input wire logic i_result_ready,
  output logic [asr_pkg::FIFO_WIDTH-1:0] o_result_data
);
  // ==========================================================
  // Pin synchronisers
  logic [SYNC_STAGES-1:0] cs_sync, ck_sync, di_sync;
  logic cs_act, ck_lvl, ck_prev, rise, fall, sel;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cs_sync <= 3'h7;
      ck_sync <= 3'h0;
      di_sync <= 3'h0;
      cs_act <= 1'b0;
      ck_lvl <= 1'b0;
      ck_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[1:0], i_frame_sel_n};
      ck_sync <= {ck_sync[1:0], i_sclk};
      di_sync <= {di_sync[1:0], i_sdin};
      // Change counts only once stages two and three agree
      if (cs_sync[1] == cs_sync[2]) begin
        cs_act <= !cs_sync[2];
      end
      if (ck_sync[1] == ck_sync[2]) begin
        ck_lvl <= ck_sync[2];
      end
      ck_prev <= ck_lvl;
    end
  end

  assign sel = cs_act;
  assign rise = sel && ck_lvl && !ck_prev;
  assign fall = sel && !ck_lvl && ck_prev;

  // ==========================================================
  // Frame sequencer
  asr_state_t state, next_state;
  logic [4:0] rise_cnt, next_rise_cnt, fall_cnt, next_fall_cnt;
  logic [FRAME_BITS-1:0] shift, next_shift, din_sh, next_din_sh;
  logic [FRAME_BITS-1:0] din_word, next_din_word;
  // Shift register empties as it sends, so the frame is kept apart
  logic [FRAME_BITS-1:0] frame_word, next_frame_word;
  logic [CHAN_BITS-1:0] chan, next_chan;
  logic track, next_track, sdout, next_sdout, push;
  logic fifo_ready;

  function automatic logic [FRAME_BITS-1:0] build_frame(
    input logic [CHAN_BITS-1:0] ch,
    input logic neg,
    input logic [DATA_BITS-1:0] mag,
    input logic twos
  );
    logic [RESULT_BITS-1:0] code;
    // Sign and magnitude folded into one signed thirteen-bit code
    code = neg ? (RESULT_BITS'(0) - {1'b0, mag}) : {1'b0, mag};
    // Straight binary offsets by flipping the sign bit
    if (twos == CODE_STRAIGHT) begin
      code[RESULT_BITS-1] = !code[RESULT_BITS-1];
    end
    build_frame = {ch, code};
  endfunction

  always_comb begin
    next_state = state;
    next_rise_cnt = rise_cnt;
    next_fall_cnt = fall_cnt;
    next_shift = shift;
    next_din_sh = din_sh;
    next_din_word = din_word;
    next_frame_word = frame_word;
    next_chan = chan;
    next_track = track;
    next_sdout = sdout;
    push = 1'b0;
    case (state)
      ASR_IDLE: begin
        if (sel) begin
          // Sample is held and the word frozen at frame start
          next_state = ASR_FRAME;
          next_track = 1'b0;
          next_shift = build_frame(chan, i_sample_neg, i_sample_mag,
                                   i_twos_comp);
          next_sdout = next_shift[FRAME_BITS-1];
          next_frame_word = next_shift;
          next_rise_cnt = 5'h00;
          next_fall_cnt = 5'h00;
        end
      end
      ASR_FRAME: begin
        if (rise) begin
          next_rise_cnt = rise_cnt + 5'h01;
          if (next_rise_cnt == TRACK_EDGE_5) begin
            next_track = 1'b1;
          end
        end
        if (fall) begin
          next_fall_cnt = fall_cnt + 5'h01;
          next_din_sh = {din_sh[FRAME_BITS-2:0], di_sync[2]};
          next_shift = {shift[FRAME_BITS-2:0], 1'b0};
          next_sdout = shift[FRAME_BITS-2];
          if (next_fall_cnt == FRAME_BITS_5) begin
            next_din_word = next_din_sh;
            // Channel address field sits in bits 14 to 12, just below the top bit
            next_chan = next_din_sh[FRAME_BITS-2 -: CHAN_BITS];
            push = 1'b1;
            next_state = ASR_DONE;
          end
        end
        if (!sel) begin
          // Short frame aborts; sample goes back to tracking
          next_state = ASR_IDLE;
          next_track = 1'b1;
        end
      end
      ASR_DONE: begin
        if (!sel) begin
          next_state = ASR_IDLE;
          next_track = 1'b1;
        end
      end
      default: begin
        next_state = ASR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state <= ASR_IDLE;
      rise_cnt <= 5'h00;
      fall_cnt <= 5'h00;
      shift <= 16'h0000;
      din_sh <= 16'h0000;
      din_word <= 16'h0000;
      frame_word <= 16'h0000;
      chan <= 3'h0;
      track <= 1'b1;
      sdout <= 1'b0;
    end else begin
      state <= next_state;
      rise_cnt <= next_rise_cnt;
      fall_cnt <= next_fall_cnt;
      shift <= next_shift;
      din_sh <= next_din_sh;
      din_word <= next_din_word;
      frame_word <= next_frame_word;
      chan <= next_chan;
      track <= next_track;
      sdout <= next_sdout;
    end
  end

  assign o_sdout = sdout;
  assign o_sdout_oe = sel;
  assign o_track = track;
  assign o_channel_address = chan;
  assign o_din_word = din_word;

  // ==========================================================
  // Result buffer; a full buffer drops the push, frame still runs
  asr_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push),
    .o_in_ready(fifo_ready),
    .i_in_data(frame_word),
    .o_out_valid(o_result_valid),
    .i_out_ready(i_result_ready),
    .o_out_data(o_result_data)
  );

  // ==========================================================
  // Checks
  a_output_release: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) !cs_act |-> !o_sdout_oe)
    else $error("serial output driven outside frame");
  a_falling_shift: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) (state == ASR_FRAME && fall && sel)
    |=> o_sdout == $past(shift[FRAME_BITS-2]))
    else $error("output bit not advanced on falling edge");
  a_stable_no_fall: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) (state == ASR_FRAME && !fall && sel)
    |=> $stable(o_sdout))
    else $error("output bit changed without falling edge");
  a_track_edge: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) (state == ASR_FRAME && rise && sel
    && rise_cnt == 5'h0d) |=> o_track)
    else $error("no return to track after edge fourteen");
  a_hold_early: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) (state == ASR_FRAME && rise_cnt < 5'h0e
    && !(rise && rise_cnt == 5'h0d)) |=> !o_track || !$past(sel))
    else $error("track resumed too early");
  a_frame_start: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) (state == ASR_IDLE && sel)
    |=> state == ASR_FRAME && !o_track)
    else $error("frame select did not start conversion");
  a_msb_first: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) (state == ASR_IDLE && sel)
    |=> o_sdout == shift[FRAME_BITS-1])
    else $error("first bit is not the top bit");
  a_chan_load: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) push |=> o_channel_address
    == $past(next_din_sh[FRAME_BITS-2 -: CHAN_BITS]))
    else $error("channel address not loaded");
  a_count_push: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) push |-> fall_cnt == 5'h0f)
    else $error("result pushed at wrong bit count");
  c_full_frame: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_n) push);
  c_short_frame: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_n) state == ASR_FRAME && !sel);
  c_fifo_full: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_n) !fifo_ready);
endmodule
`default_nettype wire

// *** asr_pkg.sv ***
// Constants and types of the serial result readout block
package asr_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CHAN_BITS = 3;
  localparam int RESULT_BITS = 13;
  localparam int DATA_BITS = 12;
  localparam int TRACK_EDGE = 14;
  localparam logic [4:0] FRAME_BITS_5 = 5'h10;
  localparam logic [4:0] TRACK_EDGE_5 = 5'h0e;
  localparam int SYNC_STAGES = 3;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic CODE_STRAIGHT = 1'b0;
  localparam logic CODE_TWOS = 1'b1;
  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_FRAME,
    ASR_DONE
  } asr_state_t;
endpackage

// *** asr_fifo.sv ***
// Parameterised valid/ready FIFO holding finished results
`timescale 1ns/1ps
`default_nettype none
module asr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

// *** asr_host.sv ***
// Host model driving the serial frame of the result readout
`timescale 1ns/1ps
`default_nettype none
module asr_host (
  // Clock and observed pins
  input wire logic i_clk,
  input wire logic i_sdout,
  input wire logic i_sdout_oe,
  input wire logic i_track,
  // Driven pins
  output logic o_frame_sel_n,
  output logic o_sclk,
  output logic o_sdin
);
  logic last = 1'b0;
  // Released line reads inverted, so a stale bit never matches
  wire logic sd_line = i_sdout_oe ? i_sdout : ~last;
  initial begin
    o_frame_sel_n = 1'b1;
    o_sclk = 1'b1;
    o_sdin = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_sdout_oe)
      last <= i_sdout;
  end
  // ==========================================
  // Frame of n clocks, half period h; idle clock high
  task automatic frame(input logic [15:0] din, input int n, input int h,
      output logic [15:0] got, output logic [15:0] trk);
    got = '0;
    trk = '0;
    o_frame_sel_n = 1'b0;
    #(2 * h);
    for (int i = 0; i < n; i++) begin
      o_sdin = din[15-i];
      #(h / 2);
      got[15-i] = sd_line;
      trk[i] = i_track;
      o_sclk = 1'b0;
      #h;
      o_sclk = 1'b1;
      #(h / 2);
    end
    #h;
    o_frame_sel_n = 1'b1;
    o_sdin = ~o_sdin;
    #(4 * h);
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the serial result readout
`timescale 1ns/1ps
`default_nettype none
module tb;
  import asr_pkg::*;
  typedef struct packed {
    logic [2:0] ch;
    logic [11:0] mag;
    logic neg;
    logic twos;
  } asr_row_t;
  // Negative samples only in twos complement rows
  asr_row_t rows [8] = '{'{3'h1, 12'h000, 1'b0, 1'b1},
    '{3'h3, 12'hfff, 1'b1, 1'b1}, '{3'h2, 12'h800, 1'b1, 1'b1},
    '{3'h7, 12'h001, 1'b0, 1'b0}, '{3'h5, 12'h5a3, 1'b1, 1'b1},
    '{3'h4, 12'ha5c, 1'b0, 1'b0}, '{3'h6, 12'h7ff, 1'b0, 1'b0},
    '{3'h0, 12'h123, 1'b1, 1'b1}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_n, sclk, sdin, sdout, oe, track, neg, twos, valid, ready;
  logic [11:0] mag;
  logic [2:0] chan, cur;
  logic [15:0] din_word, rdata, got, trk, last_din;
  logic [15:0] expq [$];
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  asr_readout asr_readout_i (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_frame_sel_n(sel_n),
    .i_sclk(sclk), .i_sdin(sdin), .o_sdout(sdout), .o_sdout_oe(oe),
    .i_sample_mag(mag), .i_sample_neg(neg), .i_twos_comp(twos),
    .o_track(track), .o_channel_address(chan), .o_din_word(din_word),
    .o_result_valid(valid), .i_result_ready(ready),
    .o_result_data(rdata));
  asr_host asr_host_i (.i_clk(clk), .i_sdout(sdout), .i_sdout_oe(oe),
    .i_track(track), .o_frame_sel_n(sel_n), .o_sclk(sclk),
    .o_sdin(sdin));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report;
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // One frame of row r: n clocks of half period h
  task automatic run(input asr_row_t r, input int n, input int h);
    logic [12:0] v;
    logic [15:0] d;
    d = {r.twos, r.ch, r.mag};
    v = r.neg ? 13'h0 - {1'b0, r.mag} : {1'b0, r.mag};
    v[12] = v[12] ^ ~r.twos;
    @(posedge clk);
    #1;
    mag = r.mag;
    neg = r.neg;
    twos = r.twos;
    asr_host_i.frame(d, n, h, got, trk);
    if (n == 16) begin
      chk(got, {cur, v});
      chk(trk & 16'hbfff, 16'h8000);
      expq.push_back({cur, v});
      last_din = d;
      cur = r.ch;
    end
    chk(din_word, last_din);
    chk({13'h0, chan}, {13'h0, cur});
    chk({15'h0, oe}, 16'h0);
  endtask
  task automatic pop;
    chk({15'h0, valid}, 16'h1);
    chk(rdata, expq.pop_front());
    ready = 1'b1;
    @(posedge clk);
    #1;
    ready = 1'b0;
    @(posedge clk);
    #1;
  endtask
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      final_report();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    mag = '0;
    neg = 1'b0;
    twos = 1'b0;
    ready = 1'b0;
    cur = 3'h0;
    last_din = '0;
    repeat (20) @(posedge clk);
    #1;
    chk({10'h0, track, oe, valid, chan}, 16'h0020);
    chk(din_word, 16'h0);
    rst_n = 1'b1;
    // Drain side stalls while the FIFO fills
    for (int k = 0; k < 8; k++) run(rows[k], 16, 200);
    // Ninth result meets a full FIFO and is dropped
    run(rows[3], 16, 200);
    void'(expq.pop_back());
    for (int k = 0; k < 8; k++) pop();
    chk({15'h0, valid}, 16'h0);
    run(rows[1], 10, 200);
    chk({15'h0, valid}, 16'h0);
    // Slow host: conversion waits on the clocks it is given
    run(rows[4], 16, 400);
    pop();
    final_report();
  end
endmodule
`default_nettype wire
